// ==== sdtc_pkg.sv ====
/*
  shared constants, bus-state encoding and the bus-state function for the
  data-bus termination control pair; assumes a 50 MHz core clock on both ends.
*/
package sdtc_pkg;
  // core clock and master clock timing
  localparam int CORE_PERIOD_NS = 20;
  localparam int MCLK_PERIOD_NS = 320;
  localparam int MCLK_HALF_CYC = MCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  // idle counts used by the controller around turnarounds
  localparam int RD_PRE_IDLES = 1;
  localparam int RD_POST_IDLES = 3;
  localparam int WR_PRE_IDLES = 3;
  localparam logic [3:0] CNT_RST = 4'h0;
  // values after reset: read/write select high, no read in flight
  localparam logic RW_RST = 1'b1;
  localparam logic CSN_RST = 1'b1;
  localparam logic RD_RST = 1'b0;

  typedef enum logic [2:0] {
    BS_LOW = 3'b001,
    BS_TERM = 3'b010,
    BS_DATA = 3'b100
  } sdtc_bus_e;

  typedef enum logic [4:0] {
    C_RD = 5'b00001,
    C_RTW = 5'b00010,
    C_WPRE = 5'b00100,
    C_WR = 5'b01000,
    C_WTR = 5'b10000
  } sdtc_cst_e;

  // bus state of cycle k from the op of k-3 and the select of k-2
  function automatic sdtc_bus_e sdtc_bus_state(input logic rd_k3, input logic rw_k2);
    if (rd_k3 && rw_k2) begin
      return BS_DATA;
    end else if (rw_k2) begin
      return BS_LOW;
    end
    return BS_TERM;
  endfunction : sdtc_bus_state
endpackage : sdtc_pkg

// ==== sdtc_if.sv ====
/*
  link between memory device end and controller end; resolves the shared
  data bus from both output enables; assumes the bench instantiates it.
*/
`timescale 1ns/1ps
interface sdtc_if #(
  parameter int DW = 18
);
  logic master_clock;
  logic cycle_select_n;
  logic rw_sel;
  logic write_data_clock;
  logic [DW-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic bus_terminate_mode;
  logic [DW-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic ctl_terminate;
  logic [DW-1:0] dq;
  logic bus_float;

  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  assign bus_float = !dev_dq_oe && !ctl_dq_oe;

  modport dev (
    input master_clock, cycle_select_n, rw_sel, write_data_clock, dq,
    output dev_dq_o, dev_dq_oe, bus_terminate_mode
  );
  modport ctl (
    output master_clock, cycle_select_n, rw_sel, write_data_clock,
    output ctl_dq_o, ctl_dq_oe, ctl_terminate,
    input dq
  );
endinterface : sdtc_if

// ==== sdtc_dev.sv ====
/*
  memory device end: samples the selects on master clock rises, places the
  data bus in drive-low, termination or read-data state, latches write beats.
  assumes all link inputs are asynchronous to core_clk and the controller
  holds the selects stable around each master clock rise.
*/
`timescale 1ns/1ps
module sdtc_dev
  import sdtc_pkg::*;
#(
  parameter int DW = 18
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link
  sdtc_if.dev lnk,
  // array read side
  output logic rd_req,
  input wire logic [2*DW-1:0] rd_data,
  // array write side
  output logic wr_valid,
  output logic [2*DW-1:0] wr_data,
  // status
  output sdtc_bus_e bus_state,
  output logic seq_err
);
  // synchronisers
  logic mck1_r, mck2_r, mck3_r;
  logic csn1_r, csn2_r;
  logic rw1_r, rw2_r;
  logic wdc1_r, wdc2_r, wdc3_r;
  logic [DW-1:0] dq1_r, dq2_r;
  // pipeline of sampled ops
  logic [2:0] rdp_r, rdp_nxt;
  logic [2:0] rwp_r, rwp_nxt;
  logic [2*DW-1:0] dat_r [3];
  logic [2*DW-1:0] dat_nxt [3];
  logic wr0_r, wr0_nxt;
  // bus drive
  sdtc_bus_e st_r, st_nxt;
  logic [DW-1:0] dqo_r, dqo_nxt;
  logic [DW-1:0] q2_r, q2_nxt;
  // write capture
  logic wpend_r, wpend_nxt;
  logic [DW-1:0] wb1_r, wb1_nxt;
  logic [2*DW-1:0] wd_r, wd_nxt;
  logic wv_r, wv_nxt;
  logic err_r, err_nxt;

  logic m_rise, m_fall, k_rise, k_fall;
  logic op_rd, op_wr;

  assign m_rise = mck2_r && !mck3_r;
  assign m_fall = !mck2_r && mck3_r;
  assign k_rise = wdc2_r && !wdc3_r;
  assign k_fall = !wdc2_r && wdc3_r;
  assign op_rd = !csn2_r && rw2_r;
  assign op_wr = !csn2_r && !rw2_r;

  assign rd_req = clk_en && m_rise && op_rd;
  assign wr_valid = wv_r;
  assign wr_data = wd_r;
  assign bus_state = st_r;
  assign seq_err = err_r;
  assign lnk.dev_dq_o = dqo_r;
  assign lnk.dev_dq_oe = (st_r != BS_TERM);
  assign lnk.bus_terminate_mode = (st_r == BS_TERM);

  always_comb begin
    rdp_nxt = rdp_r;
    rwp_nxt = rwp_r;
    dat_nxt = dat_r;
    wr0_nxt = wr0_r;
    st_nxt = st_r;
    dqo_nxt = dqo_r;
    q2_nxt = q2_r;
    wpend_nxt = wpend_r;
    wb1_nxt = wb1_r;
    wd_nxt = wd_r;
    wv_nxt = 1'b0;
    err_nxt = 1'b0;
    if (m_rise) begin
      // state of the cycle now starting, from the ops three and two back
      st_nxt = sdtc_bus_state(rdp_r[2], rwp_r[1]);
      if (st_nxt == BS_DATA) begin
        dqo_nxt = dat_r[2][DW-1:0];
        q2_nxt = dat_r[2][2*DW-1:DW];
      end else begin
        dqo_nxt = '0;
      end
      // read followed by a write-side select: bus state is not guaranteed
      err_nxt = rdp_r[0] && !rw2_r;
      wpend_nxt = wr0_r;
      rdp_nxt = {rdp_r[1:0], op_rd};
      rwp_nxt = {rwp_r[1:0], rw2_r};
      dat_nxt[2] = dat_r[1];
      dat_nxt[1] = dat_r[0];
      dat_nxt[0] = rd_data;
      wr0_nxt = op_wr;
    end else if (m_fall && st_r == BS_DATA) begin
      dqo_nxt = q2_r;
    end
    if (wpend_r && k_rise) begin
      wb1_nxt = dq2_r;
    end
    if (wpend_r && k_fall) begin
      wd_nxt = {dq2_r, wb1_r};
      wv_nxt = 1'b1;
      if (!m_rise) begin
        wpend_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mck1_r <= 1'b0;
      mck2_r <= 1'b0;
      mck3_r <= 1'b0;
      csn1_r <= CSN_RST;
      csn2_r <= CSN_RST;
      rw1_r <= RW_RST;
      rw2_r <= RW_RST;
      wdc1_r <= 1'b0;
      wdc2_r <= 1'b0;
      wdc3_r <= 1'b0;
      dq1_r <= '0;
      dq2_r <= '0;
      rdp_r <= {3{RD_RST}};
      rwp_r <= {3{RW_RST}};
      dat_r[0] <= '0;
      dat_r[1] <= '0;
      dat_r[2] <= '0;
      wr0_r <= 1'b0;
      st_r <= BS_LOW;
      dqo_r <= '0;
      q2_r <= '0;
      wpend_r <= 1'b0;
      wb1_r <= '0;
      wd_r <= '0;
      wv_r <= 1'b0;
      err_r <= 1'b0;
    end else if (clk_en) begin
      mck1_r <= lnk.master_clock;
      mck2_r <= mck1_r;
      mck3_r <= mck2_r;
      csn1_r <= lnk.cycle_select_n;
      csn2_r <= csn1_r;
      rw1_r <= lnk.rw_sel;
      rw2_r <= rw1_r;
      wdc1_r <= lnk.write_data_clock;
      wdc2_r <= wdc1_r;
      wdc3_r <= wdc2_r;
      dq1_r <= lnk.dq;
      dq2_r <= dq1_r;
      rdp_r <= rdp_nxt;
      rwp_r <= rwp_nxt;
      dat_r <= dat_nxt;
      wr0_r <= wr0_nxt;
      st_r <= st_nxt;
      dqo_r <= dqo_nxt;
      q2_r <= q2_nxt;
      wpend_r <= wpend_nxt;
      wb1_r <= wb1_nxt;
      wd_r <= wd_nxt;
      wv_r <= wv_nxt;
      err_r <= err_nxt;
    end
  end
endmodule : sdtc_dev

// ==== sdtc_ctl.sv ====
/*
  controller end: divides core_clk into the master and write data clocks,
  issues reads, writes and typed idles, drives write beats, captures read
  beats and switches its own termination; assumes HALF of at least 8.
*/
`timescale 1ns/1ps
module sdtc_ctl
  import sdtc_pkg::*;
#(
  parameter int DW = 18,
  parameter int HALF = MCLK_HALF_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link
  sdtc_if.ctl lnk,
  // request side
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [2*DW-1:0] req_wdata,
  output logic req_ready,
  // read answer
  output logic rd_valid,
  output logic [2*DW-1:0] rd_data
);
  localparam int PW = $clog2(2 * HALF);
  logic [PW-1:0] ph_r, ph_nxt;
  logic mck_r, mck_nxt, wdc_r, wdc_nxt;
  logic csn_r, csn_nxt, rw_r, rw_nxt;
  sdtc_cst_e cs_r, cs_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] rdp_r, rdp_nxt, rwp_r, rwp_nxt;
  logic [1:0] wrp_r, wrp_nxt;
  logic [2*DW-1:0] wdi_r, wdi_nxt, wd0_r, wd0_nxt, wd1_r, wd1_nxt;
  sdtc_bus_e cst_r, cst_nxt, nst_r, nst_nxt;
  logic [DW-1:0] dqo_r, dqo_nxt, rb1_r, rb1_nxt, dq1_r, dq2_r;
  logic [2*DW-1:0] rdd_r, rdd_nxt;
  logic rv_r, rv_nxt;
  logic tick, rise, wcyc, term;

  assign tick = (ph_r == PW'(HALF - 1));
  assign rise = (ph_r == PW'(2 * HALF - 1));
  assign wcyc = wrp_r[1];
  assign term = !wcyc && (cst_r == BS_DATA || nst_r == BS_DATA);
  assign req_ready = clk_en && tick && req_valid && ((cs_r == C_RD && req_read) || (cs_r == C_WR && !req_read));
  assign rd_valid = rv_r;
  assign rd_data = rdd_r;
  assign lnk.master_clock = mck_r;
  assign lnk.write_data_clock = wdc_r;
  assign lnk.cycle_select_n = csn_r;
  assign lnk.rw_sel = rw_r;
  assign lnk.ctl_dq_o = dqo_r;
  assign lnk.ctl_dq_oe = !term;
  assign lnk.ctl_terminate = term;

  always_comb begin
    ph_nxt = rise ? '0 : PW'(ph_r + 1'b1);
    mck_nxt = (ph_nxt < PW'(HALF));
    // write clock toggles only in write beat cycles, still otherwise
    wdc_nxt = wcyc && (ph_nxt >= PW'(HALF / 2)) && (ph_nxt < PW'(HALF + HALF / 2));
    csn_nxt = csn_r;
    rw_nxt = rw_r;
    cs_nxt = cs_r;
    cnt_nxt = cnt_r;
    wdi_nxt = wdi_r;
    rdp_nxt = rdp_r;
    rwp_nxt = rwp_r;
    wrp_nxt = wrp_r;
    wd0_nxt = wd0_r;
    wd1_nxt = wd1_r;
    cst_nxt = cst_r;
    nst_nxt = nst_r;
    dqo_nxt = dqo_r;
    rb1_nxt = rb1_r;
    rdd_nxt = rdd_r;
    rv_nxt = 1'b0;
    if (tick) begin
      csn_nxt = !req_ready;
      case (cs_r)
        C_RD: begin
          rw_nxt = 1'b1;
          if (req_valid && !req_read) begin
            cs_nxt = C_RTW;
            cnt_nxt = 4'h1;
          end
        end
        C_RTW: begin
          rw_nxt = 1'b1;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == 4'(RD_POST_IDLES)) begin
            cs_nxt = C_WPRE;
            cnt_nxt = CNT_RST;
          end
        end
        C_WPRE: begin
          rw_nxt = 1'b0;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == 4'(WR_PRE_IDLES)) begin
            cs_nxt = C_WR;
            cnt_nxt = CNT_RST;
          end
        end
        C_WR: begin
          rw_nxt = 1'b0;
          if (req_valid && req_read) begin
            rw_nxt = 1'b1;
            cs_nxt = (RD_PRE_IDLES == 1) ? C_RD : C_WTR;
            cnt_nxt = 4'h1;
          end
          if (req_ready) begin
            wdi_nxt = req_wdata;
          end
        end
        C_WTR: begin
          rw_nxt = 1'b1;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == 4'(RD_PRE_IDLES)) begin
            cs_nxt = C_RD;
            cnt_nxt = CNT_RST;
          end
        end
        default: begin
          cs_nxt = C_RD;
        end
      endcase
      if (wcyc) begin
        dqo_nxt = wd1_r[2*DW-1:DW];
      end
      if (cst_r == BS_DATA) begin
        rb1_nxt = dq2_r;
      end
    end
    if (rise) begin
      rdp_nxt = {rdp_r[2:0], !csn_r && rw_r};
      rwp_nxt = {rwp_r[2:0], rw_r};
      wrp_nxt = {wrp_r[0], !csn_r && !rw_r};
      wd0_nxt = wdi_r;
      wd1_nxt = wd0_r;
      cst_nxt = sdtc_bus_state(rdp_nxt[3], rwp_nxt[2]);
      nst_nxt = sdtc_bus_state(rdp_nxt[2], rwp_nxt[1]);
      dqo_nxt = wrp_nxt[1] ? wd0_r[DW-1:0] : '0;
      if (cst_r == BS_DATA) begin
        rdd_nxt = {dq2_r, rb1_r};
        rv_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_r <= '0;
      mck_r <= 1'b1;
      wdc_r <= 1'b0;
      csn_r <= CSN_RST;
      rw_r <= RW_RST;
      cs_r <= C_RD;
      cnt_r <= CNT_RST;
      wdi_r <= '0;
      rdp_r <= {4{RD_RST}};
      rwp_r <= {4{RW_RST}};
      wrp_r <= 2'h0;
      wd0_r <= '0;
      wd1_r <= '0;
      cst_r <= BS_LOW;
      nst_r <= BS_LOW;
      dqo_r <= '0;
      rb1_r <= '0;
      rdd_r <= '0;
      rv_r <= 1'b0;
      dq1_r <= '0;
      dq2_r <= '0;
    end else if (clk_en) begin
      ph_r <= ph_nxt;
      mck_r <= mck_nxt;
      wdc_r <= wdc_nxt;
      csn_r <= csn_nxt;
      rw_r <= rw_nxt;
      cs_r <= cs_nxt;
      cnt_r <= cnt_nxt;
      wdi_r <= wdi_nxt;
      rdp_r <= rdp_nxt;
      rwp_r <= rwp_nxt;
      wrp_r <= wrp_nxt;
      wd0_r <= wd0_nxt;
      wd1_r <= wd1_nxt;
      cst_r <= cst_nxt;
      nst_r <= nst_nxt;
      dqo_r <= dqo_nxt;
      rb1_r <= rb1_nxt;
      rdd_r <= rdd_nxt;
      rv_r <= rv_nxt;
      dq1_r <= lnk.dq;
      dq2_r <= dq1_r;
    end
  end
endmodule : sdtc_ctl

// ==== sdtc_monitor.sv ====
/*
  link checker: keeps select history per master rise and checks bus states.
  assumes the bench hands it the link signals and the controller's clock.
*/
`timescale 1ns/1ps
module sdtc_monitor #(
  parameter int DW = 18
) (
  // clock, reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link
  input wire logic master_clock,
  input wire logic cycle_select_n,
  input wire logic rw_sel,
  input wire logic write_data_clock,
  input wire logic [DW-1:0] dev_dq_o,
  input wire logic dev_dq_oe,
  input wire logic bus_terminate_mode,
  input wire logic [DW-1:0] ctl_dq_o,
  input wire logic ctl_dq_oe,
  input wire logic ctl_terminate,
  input wire logic [DW-1:0] dq,
  input wire logic bus_float
);
  logic mclk_r, mclk_nxt, rise, mid;
  logic [3:0] rw_r, rw_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic [4:0] ph_r, ph_nxt;
  assign rise = master_clock && !mclk_r;
  assign mid = ph_r == 5'h06 || ph_r == 5'h0E;
  // history of selects, index 0 is the latest master rise
  always_comb begin
    mclk_nxt = master_clock;
    rw_nxt = rw_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    ph_nxt = (ph_r == 5'h1F) ? ph_r : ph_r + 5'h01;
    if (rise) begin
      rw_nxt = {rw_r[2:0], rw_sel};
      rd_nxt = {rd_r[2:0], !cycle_select_n && rw_sel};
      wr_nxt = {wr_r[2:0], !cycle_select_n && !rw_sel};
      ph_nxt = 5'h00;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_r <= 1'b1;
      rw_r <= 4'hF;
      rd_r <= 4'h0;
      wr_r <= 4'h0;
      ph_r <= 5'h1F;
    end else begin
      mclk_r <= mclk_nxt;
      rw_r <= rw_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      ph_r <= ph_nxt;
    end
  end
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  AST_LOW: assert property (mid && rw_r[2] && !rd_r[3] |-> dev_dq_oe && !bus_terminate_mode && dev_dq_o == '0)
    else $error("bus not low");
  AST_TERM: assert property (mid && !rw_r[2] && !rd_r[3] |-> bus_terminate_mode && !dev_dq_oe && ctl_dq_oe)
    else $error("bus not terminated");
  AST_RDATA: assert property (mid && rw_r[2] && rd_r[3] |-> dev_dq_oe && !bus_terminate_mode && ctl_terminate)
    else $error("no read data");
  AST_CTL_LOW: assert property (mid && !wr_r[1] |-> !ctl_dq_oe || ctl_dq_o == '0)
    else $error("controller not driving low");
  AST_NO_FLOAT: assert property (mid |-> !bus_float)
    else $error("bus floats");
  AST_WBEAT: assert property (mid && wr_r[1] |-> bus_terminate_mode && ctl_dq_oe && dq == ctl_dq_o)
    else $error("write beat not received");
  AST_WCLK: assert property ($rose(write_data_clock) |-> wr_r[1])
    else $error("stray write clock");
  AST_SEL_HOLD: assert property (rise |-> $stable(rw_sel) && $stable(cycle_select_n) ##1 $stable(rw_sel) [*3])
    else $error("select moved at rise");
  AST_RD_FOLLOW: assert property (rise && rd_r[0] |-> rw_sel)
    else $error("write side after read");
  AST_POST_IDLES: assert property (rise && !rw_sel |-> rd_r[2:0] == 3'h0)
    else $error("too few idles after read");
  AST_PRE_IDLES: assert property (rise && !cycle_select_n && !rw_sel |-> rw_r[2:0] == 3'h0)
    else $error("too few idles before write");
endmodule : sdtc_monitor

// ==== tb_top.sv ====
/*
  bench: both ends on one link for writes, reads and turnarounds, and a
  lone device fed select sequences by the bench; assumes design compiled.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int DW = 18;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [2*DW-1:0] req_wdata = '0;
  logic req_ready, rd_valid, rd_req, wr_valid, seq_err, f_seq_err;
  logic [2*DW-1:0] rd_data, wr_data, arr_q;
  sdtc_pkg::sdtc_bus_e f_bus_state;
  logic [DW-1:0] rd_cnt = '0;
  logic [DW-1:0] nrd = '0;
  int num_errors = 0;
  int num_checks = 0;
  int nf = 0;
  int nm = 0;
  logic [2*DW-1:0] rq[$], wq[$], erq[$], ewq[$];
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  sdtc_if #(.DW(DW)) sdtc_if_i ();
  sdtc_if #(.DW(DW)) f_if ();
  sdtc_ctl #(.DW(DW)) sdtc_ctl_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .lnk(sdtc_if_i.ctl), .req_valid(req_valid), .req_read(req_read), .req_wdata(req_wdata),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  sdtc_dev #(.DW(DW)) sdtc_dev_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .lnk(sdtc_if_i.dev), .rd_req(rd_req), .rd_data(arr_q), .wr_valid(wr_valid),
    .wr_data(wr_data), .bus_state(), .seq_err(seq_err));
  sdtc_dev #(.DW(DW)) sdtc_dev_f (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .lnk(f_if.dev), .rd_req(), .rd_data(arr_q), .wr_valid(), .wr_data(), .bus_state(f_bus_state),
    .seq_err(f_seq_err));
  sdtc_monitor #(.DW(DW)) sdtc_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .master_clock(sdtc_if_i.master_clock), .cycle_select_n(sdtc_if_i.cycle_select_n),
    .rw_sel(sdtc_if_i.rw_sel), .write_data_clock(sdtc_if_i.write_data_clock),
    .dev_dq_o(sdtc_if_i.dev_dq_o), .dev_dq_oe(sdtc_if_i.dev_dq_oe),
    .bus_terminate_mode(sdtc_if_i.bus_terminate_mode), .ctl_dq_o(sdtc_if_i.ctl_dq_o),
    .ctl_dq_oe(sdtc_if_i.ctl_dq_oe), .ctl_terminate(sdtc_if_i.ctl_terminate),
    .dq(sdtc_if_i.dq), .bus_float(sdtc_if_i.bus_float));
  // array answers the k-th read with {~k, k}
  assign arr_q = {~rd_cnt, rd_cnt};
  always @(posedge core_clk) begin
    if (rd_req === 1'b1) rd_cnt <= rd_cnt + 1'b1;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_valid === 1'b1) wq.push_back(wr_data);
    if (f_seq_err === 1'b1) nf++;
    if (seq_err === 1'b1) nm++;
  end
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; leaves the request up when taken
  task automatic issue(input logic rd, input logic [2*DW-1:0] d);
    int n;
    req_valid <= 1'b1;
    req_read <= rd;
    req_wdata <= d;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    if (n >= 400) begin
      num_errors++;
      results();
    end
    @(posedge core_clk);
    if (rd) begin
      erq.push_back({~nrd, nrd});
      nrd = nrd + 1'b1;
    end else begin
      ewq.push_back(d);
    end
  endtask : issue
  task automatic drain();
    int n;
    req_valid <= 1'b0;
    n = 0;
    while ((rq.size() < erq.size() || wq.size() < ewq.size()) && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      results();
    end
    while (erq.size() > 0) chk(rq.pop_front(), erq.pop_front());
    while (ewq.size() > 0) chk(wq.pop_front(), ewq.pop_front());
    @(posedge core_clk);
  endtask : drain
  task automatic sc_writes();
    issue(1'b0, 36'hFFFFFFFFF);
    issue(1'b0, 36'h000000000);
    issue(1'b0, 36'h9A5C3E17B);
    drain();
  endtask : sc_writes
  task automatic sc_reads();
    repeat (3) issue(1'b1, '0);
    drain();
  endtask : sc_reads
  task automatic sc_turn();
    issue(1'b0, 36'h123456789);
    issue(1'b1, '0);
    issue(1'b0, 36'hEDCBA9876);
    issue(1'b1, '0);
    issue(1'b1, '0);
    issue(1'b0, 36'h0F0F0F0F0);
    drain();
  endtask : sc_turn
  // one master cycle on the lone device, 160 ns period
  task automatic fcyc(input logic csn, input logic rw);
    f_if.cycle_select_n <= csn;
    f_if.rw_sel <= rw;
    repeat (2) @(posedge core_clk);
    f_if.master_clock <= 1'b1;
    repeat (4) @(posedge core_clk);
    f_if.master_clock <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : fcyc
  task automatic sc_fault();
    fcyc(1'b0, 1'b1);
    chk(36'(f_bus_state), 36'(sdtc_pkg::BS_LOW));
    fcyc(1'b1, 1'b1);
    repeat (2) fcyc(1'b1, 1'b0);
    chk(36'(f_bus_state), 36'(sdtc_pkg::BS_DATA));
    fcyc(1'b1, 1'b0);
    chk(36'(f_bus_state), 36'(sdtc_pkg::BS_TERM));
    chk(36'(nf), 36'h0);
    fcyc(1'b0, 1'b1);
    repeat (3) fcyc(1'b1, 1'b0);
    chk(36'(nf), 36'h1);
    chk(36'(f_bus_state), 36'(sdtc_pkg::BS_TERM));
  endtask : sc_fault
  initial begin
    f_if.master_clock = 1'b0;
    f_if.cycle_select_n = 1'b1;
    f_if.rw_sel = 1'b1;
    f_if.write_data_clock = 1'b0;
    f_if.ctl_dq_o = '0;
    f_if.ctl_dq_oe = 1'b1;
    f_if.ctl_terminate = 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    sc_writes();
    sc_reads();
    sc_turn();
    sc_fault();
    chk(36'(nm), 36'h0);
    results();
  end
endmodule : tb_top
